// File: rtl/gds_cfg.svh
// Index map, field positions, reset values and timing counts of the gamma slave
`ifndef GDS_CFG_SVH
`define GDS_CFG_SVH
`define GDS_IDX_FIRST_CH0   5'h00
`define GDS_IDX_FIRST_CH11  5'h0b
`define GDS_IDX_SECOND_CH0  5'h10
`define GDS_IDX_SECOND_CH11 5'h1b
`define GDS_IDX_BANK_POS    4
`define GDS_CH_LAST         4'hb
`define GDS_CH_FIRST        4'h0
`define GDS_ADDR_HI6        6'h3a
`define GDS_HI_LOAD_POS     7
`define GDS_LEVEL_RST       10'h000
`define GDS_BYTE_BITS       4'h8
`define GDS_LOAD_TIME_NS    1000
`define GDS_REF_PERIOD_NS   4
`define GDS_LOAD_CYC        ((`GDS_LOAD_TIME_NS) / (`GDS_REF_PERIOD_NS))
`endif

// File: rtl/gds_pkg.sv
// Types shared by the gamma two-wire slave
package gds_pkg;
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_INDEX     = 4'h3,
		ST_INDEX_ACK = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RACK      = 4'h8
	} gds_state_t;
	typedef logic [9:0] gds_level_t;
	typedef struct packed {
		logic out;
		logic oe_n;
	} gds_sda_drv_t;
	typedef struct packed {
		logic scl;
		logic sda;
		logic latch;
		logic curve;
		logic strap;
	} gds_pins_t;
endpackage : gds_pkg

// File: rtl/gds_twowire_slave.sv
// Two-wire slave with double-buffered gamma level stores and output load
`timescale 1ns/100ps
`include "gds_cfg.svh"
module gds_twowire_slave
	import gds_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    link_clk,
	input  wire logic                    scl_pin,
	input  wire logic                    sda_in,
	input  wire logic                    output_latch_pin,
	input  wire logic                    curve_select_pin,
	input  wire logic                    slave_addr_strap,
	output gds_sda_drv_t                 sda_drv,
	output logic [11:0][9:0]             dac_level
);
	localparam int NUM_CH     = 12;
	localparam int LOAD_CYC_I = `GDS_LOAD_CYC;

	// Link domain
	gds_pins_t                           pin_s1_reg;
	gds_pins_t                           pin_s2_reg;
	gds_pins_t                           pin_prev_reg;
	logic [1:0]                          strap_wait_reg;
	logic                                strap_reg;
	gds_state_t                          state_reg;
	logic [3:0]                          cnt_reg;
	logic [7:0]                          shift_reg;
	logic [7:0]                          tx_reg;
	logic [4:0]                          ptr_reg;
	logic                                rw_reg;
	logic                                byte_sel_reg;
	logic [7:0]                          hi_reg;
	gds_sda_drv_t                        sda_drv_reg;
	logic [1:0][NUM_CH-1:0][9:0]         bank_reg;
	logic                                pend_reg;
	logic                                req_tgl_reg;
	logic [NUM_CH-1:0][9:0]              img_reg;
	logic [1:0]                          ack_sync_reg;
	// Reference domain
	logic [1:0]                          req_sync_reg;
	logic                                ack_tgl_reg;
	logic [NUM_CH-1:0][9:0]              dac_level_reg;
	logic [1:0]                          lat_ref_sync_reg;

	logic                                scl_rise;
	logic                                scl_fall;
	logic                                start_det;
	logic                                stop_det;
	logic                                byte_done;
	logic                                wr_commit;
	logic                                sw_load;
	logic                                load_set;
	logic                                busy;
	logic                                issue;
	logic [4:0]                          ptr_next;
	gds_level_t                          rd_lvl;
	gds_level_t                          rd_lvl_next;
	logic [7:0]                          rd_hi_next;

	function automatic logic idx_valid(input logic [7:0] b);
		logic [4:0] i;
		i = b[4:0];
		idx_valid = (b[7:5] == 3'h0) &&
			((i <= `GDS_IDX_FIRST_CH11) ||
			 ((i >= `GDS_IDX_SECOND_CH0) && (i <= `GDS_IDX_SECOND_CH11)));
	endfunction : idx_valid

	function automatic logic [4:0] next_idx(input logic [4:0] p);
		logic [3:0] ch;
		ch = (p[3:0] == `GDS_CH_LAST) ? `GDS_CH_FIRST : p[3:0] + 4'h1;
		next_idx = {p[`GDS_IDX_BANK_POS], ch};
	endfunction : next_idx

	// Pin synchronisers, second stage feeds all logic
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			pin_s1_reg   <= 5'h18;
			pin_s2_reg   <= 5'h18;
			pin_prev_reg <= 5'h18;
		end else begin
			pin_s1_reg   <= '{scl: scl_pin, sda: sda_in, latch: output_latch_pin,
				curve: curve_select_pin, strap: slave_addr_strap};
			pin_s2_reg   <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
		end
	end

	// Strap taken once the synchroniser holds the pin, third edge after release
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			strap_wait_reg <= 2'h0;
			strap_reg      <= 1'b0;
		end else if (strap_wait_reg != 2'h3) begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
			strap_reg      <= pin_s2_reg.strap;
		end
	end

	assign scl_rise  = pin_s2_reg.scl & ~pin_prev_reg.scl;
	assign scl_fall  = ~pin_s2_reg.scl & pin_prev_reg.scl;
	assign start_det = pin_s2_reg.scl & pin_prev_reg.scl & pin_prev_reg.sda & ~pin_s2_reg.sda;
	assign stop_det  = pin_s2_reg.scl & pin_prev_reg.scl & ~pin_prev_reg.sda & pin_s2_reg.sda;
	assign byte_done = scl_fall && (cnt_reg == `GDS_BYTE_BITS) && !start_det && !stop_det;
	assign ptr_next  = next_idx(ptr_reg);
	assign rd_lvl      = bank_reg[ptr_reg[4]][ptr_reg[3:0]];
	assign rd_lvl_next = bank_reg[ptr_next[4]][ptr_next[3:0]];
	assign rd_hi_next  = {6'h00, rd_lvl_next[9:8]};
	assign wr_commit = byte_done && (state_reg == ST_WDATA) && byte_sel_reg;

	// Bus protocol engine
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			ptr_reg      <= 5'h00;
			rw_reg       <= 1'b0;
			byte_sel_reg <= 1'b0;
			hi_reg       <= 8'h00;
			sda_drv_reg  <= 2'h1;
		end else if (start_det) begin
			// Partial pair dropped, read ended
			state_reg        <= ST_ADDR;
			cnt_reg          <= 4'h0;
			byte_sel_reg     <= 1'b0;
			sda_drv_reg.oe_n <= 1'b1;
		end else if (stop_det) begin
			state_reg        <= ST_IDLE;
			byte_sel_reg     <= 1'b0;
			sda_drv_reg.oe_n <= 1'b1;
		end else if (scl_rise) begin
			case (state_reg)
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					shift_reg <= {shift_reg[6:0], pin_s2_reg.sda};
					cnt_reg   <= cnt_reg + 4'h1;
				end
				ST_RDATA: begin
					cnt_reg <= cnt_reg + 4'h1;
				end
				ST_RACK: begin
					if (pin_s2_reg.sda) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (cnt_reg == `GDS_BYTE_BITS) begin
						cnt_reg <= 4'h0;
						if (shift_reg[7:1] == {`GDS_ADDR_HI6, strap_reg}) begin
							rw_reg           <= shift_reg[0];
							sda_drv_reg.oe_n <= 1'b0;
							state_reg        <= ST_ADDR_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					cnt_reg <= 4'h0;
					if (rw_reg) begin
						// High byte of current channel first
						sda_drv_reg.oe_n <= 1'b0;
						tx_reg           <= {5'h00, rd_lvl[9:8], 1'b0};
						byte_sel_reg     <= 1'b1;
						state_reg        <= ST_RDATA;
					end else begin
						sda_drv_reg.oe_n <= 1'b1;
						state_reg        <= ST_INDEX;
					end
				end
				ST_INDEX: begin
					if (cnt_reg == `GDS_BYTE_BITS) begin
						cnt_reg <= 4'h0;
						if (idx_valid(shift_reg)) begin
							ptr_reg          <= shift_reg[4:0];
							sda_drv_reg.oe_n <= 1'b0;
							state_reg        <= ST_INDEX_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_INDEX_ACK: begin
					sda_drv_reg.oe_n <= 1'b1;
					byte_sel_reg     <= 1'b0;
					state_reg        <= ST_WDATA;
				end
				ST_WDATA: begin
					if (cnt_reg == `GDS_BYTE_BITS) begin
						cnt_reg          <= 4'h0;
						sda_drv_reg.oe_n <= 1'b0;
						state_reg        <= ST_WDATA_ACK;
						byte_sel_reg     <= ~byte_sel_reg;
						if (!byte_sel_reg) begin
							hi_reg <= shift_reg;
						end else begin
							ptr_reg <= ptr_next;
						end
					end
				end
				ST_WDATA_ACK: begin
					sda_drv_reg.oe_n <= 1'b1;
					state_reg        <= ST_WDATA;
				end
				ST_RDATA: begin
					if (cnt_reg == `GDS_BYTE_BITS) begin
						cnt_reg          <= 4'h0;
						sda_drv_reg.oe_n <= 1'b1;
						state_reg        <= ST_RACK;
					end else begin
						sda_drv_reg.oe_n <= tx_reg[7];
						tx_reg           <= {tx_reg[6:0], 1'b0};
					end
				end
				ST_RACK: begin
					// Master acked, present next byte
					cnt_reg      <= 4'h0;
					byte_sel_reg <= ~byte_sel_reg;
					state_reg    <= ST_RDATA;
					if (byte_sel_reg) begin
						sda_drv_reg.oe_n <= rd_lvl[7];
						tx_reg           <= {rd_lvl[6:0], 1'b0};
					end else begin
						ptr_reg          <= ptr_next;
						sda_drv_reg.oe_n <= rd_hi_next[7];
						tx_reg           <= {rd_hi_next[6:0], 1'b0};
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Channel stores, written only by a complete pair
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			bank_reg <= {2 * NUM_CH{`GDS_LEVEL_RST}};
		end else if (wr_commit) begin
			bank_reg[ptr_reg[4]][ptr_reg[3:0]] <= {hi_reg[1:0], shift_reg};
		end
	end

	// Load requests toward the output stage
	assign sw_load  = wr_commit && hi_reg[`GDS_HI_LOAD_POS] && pin_s2_reg.latch;
	assign load_set = sw_load
		|| (pin_prev_reg.latch && !pin_s2_reg.latch)
		|| (!pin_s2_reg.latch && wr_commit)
		|| (!pin_s2_reg.latch && (pin_s2_reg.curve != pin_prev_reg.curve));
	assign busy  = req_tgl_reg != ack_sync_reg[1];
	assign issue = pend_reg && !busy;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			pend_reg     <= 1'b0;
			req_tgl_reg  <= 1'b0;
			img_reg      <= {NUM_CH{`GDS_LEVEL_RST}};
			ack_sync_reg <= 2'h0;
		end else begin
			ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
			// New request wins over the issue clear
			pend_reg <= load_set || (pend_reg && !issue);
			if (issue) begin
				img_reg     <= bank_reg[pin_s2_reg.curve];
				req_tgl_reg <= ~req_tgl_reg;
			end
		end
	end

	// Output stage, image held stable until acknowledged
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_sync_reg  <= 2'h0;
			ack_tgl_reg   <= 1'b0;
			dac_level_reg <= {NUM_CH{`GDS_LEVEL_RST}};
		end else begin
			req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
			if (req_sync_reg[1] != ack_tgl_reg) begin
				dac_level_reg <= img_reg;
				ack_tgl_reg   <= req_sync_reg[1];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lat_ref_sync_reg <= 2'h0;
		end else begin
			lat_ref_sync_reg <= {lat_ref_sync_reg[0], output_latch_pin};
		end
	end

	assign sda_drv   = sda_drv_reg;
	assign dac_level = dac_level_reg;

	chk_index_refuse: assert property (@(posedge link_clk) disable iff (rst)
		byte_done && state_reg == ST_INDEX && !idx_valid(shift_reg)
		|=> state_reg == ST_IDLE && sda_drv_reg.oe_n)
		else $error("invalid index was acknowledged");
	chk_wdata_ack: assert property (@(posedge link_clk) disable iff (rst)
		byte_done && state_reg == ST_WDATA
		|=> !sda_drv_reg.oe_n && state_reg == ST_WDATA_ACK)
		else $error("write data byte not acknowledged");
	chk_commit_low: assert property (@(posedge link_clk) disable iff (rst)
		wr_commit |=> bank_reg[$past(ptr_reg[4])][$past(ptr_reg[3:0])]
		== {$past(hi_reg[1:0]), $past(shift_reg)})
		else $error("low byte did not commit the pair");
	chk_ptr_step: assert property (@(posedge link_clk) disable iff (rst)
		wr_commit |=> ptr_reg == next_idx($past(ptr_reg)))
		else $error("pointer did not advance after pair");
	chk_start_drop: assert property (@(posedge link_clk) disable iff (rst)
		(start_det || stop_det) |=> !byte_sel_reg && $stable(bank_reg))
		else $error("partial pair survived stop or start");
	chk_sw_load: assert property (@(posedge link_clk) disable iff (rst)
		sw_load |=> pend_reg ##[0:40] issue)
		else $error("software load not issued");
	chk_addr_match: assert property (@(posedge link_clk) disable iff (rst)
		byte_done && state_reg == ST_ADDR && shift_reg[7:1] == {`GDS_ADDR_HI6, strap_reg}
		|=> state_reg == ST_ADDR_ACK && !sda_drv_reg.oe_n)
		else $error("own address not acknowledged");
	chk_curve_pick: assert property (@(posedge link_clk) disable iff (rst)
		issue |=> img_reg == $past(bank_reg[pin_s2_reg.curve]))
		else $error("load took wrong bank");
	chk_latch_load: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(lat_ref_sync_reg[1]) |-> ##[1:LOAD_CYC_I] (req_sync_reg[1] != ack_tgl_reg))
		else $error("latch load not done in time");
	chk_rack_end: assert property (@(posedge link_clk) disable iff (rst)
		scl_rise && state_reg == ST_RACK && pin_s2_reg.sda && !start_det && !stop_det
		|=> state_reg == ST_IDLE ##1 sda_drv_reg.oe_n)
		else $error("read continued after nack");
	chk_read_msb: assert property (@(posedge link_clk) disable iff (rst)
		scl_fall && state_reg == ST_ADDR_ACK && rw_reg |=> !sda_drv_reg.oe_n)
		else $error("read high byte top bit not zero");

	cov_write_pair: cover property (@(posedge link_clk) disable iff (rst) wr_commit);
	cov_sw_load: cover property (@(posedge link_clk) disable iff (rst) sw_load);
	cov_read_pair: cover property (@(posedge link_clk) disable iff (rst)
		scl_fall && state_reg == ST_RACK && byte_sel_reg);
	cov_latch_fall: cover property (@(posedge ref_clk) disable iff (rst)
		$fell(lat_ref_sync_reg[1]));
endmodule : gds_twowire_slave

// File: bench/gds_tw_master.sv
// Two-wire bus master model for the gamma slave bench
`timescale 1ns/100ps
module gds_tw_master (
	output logic      scl_pin,
	output logic      sda_pull,
	input  wire logic sda_wire
);
	initial begin
		scl_pin = 1'b1;
		sda_pull = 1'b0;
	end
	// One bit: data moves mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		#100 sda_pull = ~b;
		#140 scl_pin = 1'b1;
		#60 r = sda_wire;
		#60 scl_pin = 1'b0;
	endtask : bit_io
	// Line released before clock rises, so a held ack ends first
	task automatic start();
		sda_pull = 1'b0;
		#200 scl_pin = 1'b1;
		#200 sda_pull = 1'b1;
		#200 scl_pin = 1'b0;
	endtask : start
	task automatic stop();
		#100 sda_pull = 1'b1;
		#140 scl_pin = 1'b1;
		#200 sda_pull = 1'b0;
		#300;
	endtask : stop
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send_byte
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask : recv_byte
endmodule : gds_tw_master

// File: bench/gds_twowire_slave_tb.sv
// Self-checking bench for the gamma two-wire slave
`timescale 1ns/100ps
module gds_twowire_slave_tb;
	import gds_pkg::*;
	logic             ref_clk, link_clk, rst, scl_pin, sda_pull, sda_wire;
	logic             latch, curve, strap, ack;
	gds_sda_drv_t     sda_drv;
	logic [11:0][9:0] dac_level;
	gds_level_t       bank [2][12];
	logic [7:0]       hb, lb;
	logic [9:0]       v;
	logic [7:0]       bad_idx [4] = '{8'h0c, 8'h1c, 8'h2b, 8'hff};
	int               err_total, check_count, cyc, ch;

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #16 link_clk = ~link_clk;
	end
	assign sda_wire = ~sda_pull & (sda_drv.oe_n | sda_drv.out);

	gds_twowire_slave gds_twowire_slave_i (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
		.scl_pin(scl_pin), .sda_in(sda_wire), .output_latch_pin(latch),
		.curve_select_pin(curve), .slave_addr_strap(strap), .sda_drv(sda_drv),
		.dac_level(dac_level));
	gds_tw_master gds_tw_master_i (.scl_pin(scl_pin), .sda_pull(sda_pull), .sda_wire(sda_wire));

	task automatic end_sim();
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	function automatic logic [11:0][9:0] bank_view(input logic sel);
		for (int c = 0; c < 12; c++)
			bank_view[c] = bank[sel][c];
	endfunction : bank_view
	// Hold waits the full load time; otherwise stop at first match
	task automatic dac_is(input logic [11:0][9:0] exp, input logic hold);
		for (int i = 0; i < 250 && (hold || dac_level !== exp); i++)
			@(negedge ref_clk);
		check(dac_level, exp);
	endtask : dac_is
	task automatic pins(input logic l, input logic c);
		@(posedge ref_clk);
		#1 latch = l;
		curve = c;
	endtask : pins
	task automatic do_reset(input logic s);
		@(posedge ref_clk);
		#1 rst = 1'b1;
		strap = s;
		repeat (5) @(posedge ref_clk);
		repeat (2) @(posedge link_clk);
		@(posedge ref_clk);
		#1 rst = 1'b0;
		repeat (8) @(posedge link_clk);
		for (int c = 0; c < 24; c++)
			bank[c / 12][c % 12] = '0;
	endtask : do_reset
	task automatic send(input logic [7:0] d, input logic exp);
		gds_tw_master_i.send_byte(d, ack);
		check(ack, exp);
	endtask : send
	task automatic addr(input logic rd, input logic good);
		gds_tw_master_i.start();
		send({6'h3a, good ~^ strap, rd}, good);
	endtask : addr
	task automatic wr(input logic b, input int c, input int n, input logic ld, input logic cut);
		addr(1'b0, 1'b1);
		send({3'h0, b, 4'(c)}, 1'b1);
		for (int k = 0; k < n; k++) begin
			v = ld ? bank[b][(c + k) % 12] : 10'($urandom);
			send({ld, 5'($urandom), v[9:8]}, 1'b1);
			send(v[7:0], 1'b1);
			bank[b][(c + k) % 12] = v;
		end
		if (cut)
			send(8'h03, 1'b1);
		gds_tw_master_i.stop();
	endtask : wr
	task automatic rd(input logic b, input int c, input int n);
		addr(1'b0, 1'b1);
		send({3'h0, b, 4'(c)}, 1'b1);
		addr(1'b1, 1'b1);
		for (int k = 0; k < n; k++) begin
			gds_tw_master_i.recv_byte(1'b1, hb);
			gds_tw_master_i.recv_byte(k < n - 1, lb);
			check({hb, lb}, {6'h0, bank[b][(c + k) % 12]});
		end
		gds_tw_master_i.stop();
	endtask : rd

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		{rst, latch, curve, strap} = 4'b1100;
		{err_total, check_count, cyc} = '0;
		void'($urandom(32'h5a353259));
		do_reset(1'b0);
		check({sda_drv, dac_level}, {2'b01, 120'h0});
		addr(1'b0, 1'b0);
		gds_tw_master_i.stop();
		for (int i = 0; i < 4; i++) begin
			addr(1'b0, 1'b1);
			send(bad_idx[i], 1'b0);
			gds_tw_master_i.stop();
		end
		wr(1'b0, 8, 4, 1'b0, 1'b0);
		dac_is('0, 1'b1);
		rd(1'b0, 9, 3);
		pins(1'b0, 1'b0);
		dac_is(bank_view(1'b0), 1'b0);
		pins(1'b1, 1'b1);
		wr(1'b1, 0, 3, 1'b0, 1'b1);
		dac_is(bank_view(1'b0), 1'b1);
		pins(1'b0, 1'b1);
		dac_is(bank_view(1'b1), 1'b0);
		wr(1'b1, 11, 1, 1'b0, 1'b0);
		dac_is(bank_view(1'b1), 1'b0);
		pins(1'b1, 1'b1);
		ch = $urandom % 12;
		wr(1'b0, ch, 1, 1'b0, 1'b0);
		dac_is(bank_view(1'b1), 1'b1);
		// Select flips while the loading write is on the bus
		fork
			wr(1'b0, ch, 1, 1'b1, 1'b0);
			begin
				#5000;
				pins(1'b1, 1'b0);
			end
		join
		dac_is(bank_view(1'b0), 1'b0);
		repeat (2) begin
			ch = $urandom % 24;
			wr(1'(ch / 12), ch % 12, 1, 1'b0, 1'b0);
			rd(1'(ch / 12), ch % 12, 1);
		end
		do_reset(1'b1);
		check(dac_level, '0);
		addr(1'b0, 1'b0);
		addr(1'b0, 1'b1);
		gds_tw_master_i.stop();
		end_sim();
	end
endmodule : gds_twowire_slave_tb
